/* core/mbq_defs.svh */
`ifndef MBQ_DEFS_SVH
`define MBQ_DEFS_SVH

// Buffer source codes; bit 0 carries weight 1, bit 2 weight 4
`define MBQ_SRC_CACHE 3'h0
`define MBQ_SRC_AR 3'h2
`define MBQ_SRC_CHBUF 3'h3
`define MBQ_SRC_MEM 3'h4
`define MBQ_SRC_CCW 3'h6

// Controller ticks between read data valid and the push into the staging FIFO
`define MBQ_DV_WAIT 2

`define MBQ_WORD_W 36
`define MBQ_FIFO_DEPTH 8
`define MBQ_IDX_ZERO 2'h0
`define MBQ_FLAGS_NONE 4'h0

`endif

/* core/mbq_pkg.sv */
package mbq_pkg;
    typedef logic [1:0] buf_idx_t;
    typedef logic [3:0] buf_flags_t;
    typedef logic [2:0] src_code_t;
endpackage

/* core/word_fifo.sv */
`timescale 1ns/100ps
module word_fifo #(
    parameter int W = 38,
    parameter int DEPTH = 8
) (
    input wire logic clk, // Controller clock
    input wire logic rst, // Synchronous reset
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word, registered
    input wire logic [W-1:0] in_data, // Word in
    output logic out_valid, // Word available
    input wire logic out_ready, // Consumer takes word
    output logic [W-1:0] out_data // Oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
    } fifo_st_t;

    fifo_st_t s_r;
    fifo_st_t s_nxt;
    logic push;
    logic pop;

    assign push = in_valid && !s_r.full;
    assign pop = out_ready && (s_r.cnt != '0);
    assign in_ready = !s_r.full;
    assign out_valid = (s_r.cnt != '0);
    assign out_data = s_r.mem[s_r.rp];

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // Registered full keeps the upstream ready free of logic
        s_nxt.full = (s_nxt.cnt == (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

/* core/memory_buffer_queue_control.sv */
`timescale 1ns/100ps
`include "mbq_defs.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Writing any buffer sets that buffer's pending flag.
// - Delivering a buffer's word clears its pending flag.
// - Buffers load from register, cache, system bus or channel.
// - Core read: first word to register, rest to cache unless one-word.
// - First word reaches cache in the cache cycle; later ones separately.
// - Buffered words feed bus writes and page table refills.
// - Queue records which buffer took the register word.
// - Cache transfer loads pending flags and cache word queue together.
// - Modified words for writeback, valid words for refill or read.
// - Bus acknowledge or channel read selection clears the flag too.
// - Outside channel reads, select next pending buffer, ascending mod 4.
// - Core stays busy until no flag is pending.
// - Priority encoder makes source code driving mixer and strobes.
// - Codes: 000 cache, 010 register, 011 channel, 100 memory, 110 ccw.
// - Buffer pointer and strobe timing follow the chosen source.
// - Stage bus read word in the FIFO two ticks after data valid.
// - Output select follows the queue, or channel choice in reads.
module memory_buffer_queue_control #(
    parameter int W = `MBQ_WORD_W,
    parameter int FIFO_DEPTH = `MBQ_FIFO_DEPTH
) (
    input wire logic clk, // Controller clock
    input wire logic rst, // Synchronous reset
    input wire logic [W-1:0] arithmetic_register, // Register data
    input wire logic [W-1:0] cache_data, // Cache read data
    input wire logic [W-1:0] mem_data, // System bus read data
    input wire logic [W-1:0] channel_data_buffer, // Channel data word
    input wire logic [W-1:0] command_word_mixer, // Command word data
    input wire logic single_word_write_phase, // Register write strobe
    input wire logic system_bus_diagnostic, // Diagnostic register load
    input wire mbq_pkg::buf_idx_t physical_word_address_bits, // Reg target
    input wire logic cache_xfer_load, // Start cache to buffer transfer
    input wire logic cache_xfer_written_only, // Writeback or validate
    input wire mbq_pkg::buf_flags_t cache_word_modified, // Written words
    input wire mbq_pkg::buf_flags_t cache_word_valid, // Valid words
    input wire logic cache_transfer_phase_three, // Cache word strobe time
    input wire logic bus_read_word_valid, // Read data valid pulse
    input wire mbq_pkg::buf_idx_t core_addr_bits, // Read word target
    input wire logic channel_buffer_load, // Channel load strobe
    input wire logic channel_load_command, // Channel load is command word
    input wire mbq_pkg::buf_idx_t channel_buffer_select, // Channel buffer
    input wire logic channel_read_active, // Channel read in progress
    input wire logic channel_read_take, // Channel reads its buffer
    input wire logic core_read_start, // Core read begins
    input wire logic core_read_one_word, // Single word read
    input wire logic ar_word_taken, // Register took selected word
    input wire logic cache_word_written, // Selected word into cache
    input wire logic page_table_written, // Selected word into page table
    input wire logic bus_word_accepted, // Core acknowledged bus write
    output logic [W-1:0] buffer_out_data, // Selected buffer contents
    output mbq_pkg::buf_idx_t buffer_output_select, // Selected buffer
    output mbq_pkg::src_code_t buffer_source_select_code, // Last source
    output mbq_pkg::buf_flags_t buffer_load_strobe, // Load pulse per buffer
    output mbq_pkg::buf_flags_t buffer_pending_flags, // Pending queue
    output mbq_pkg::buf_flags_t cache_to_buffer_word_requests, // Word queue
    output mbq_pkg::buf_idx_t cache_word_pointer, // Next cache word
    output logic any_buffer_pending, // Some flag set
    output logic core_busy, // Core held busy
    output logic ar_word_ready, // First read word ready for register
    output logic cache_word_request, // Later read word wants cache cycle
    output logic bus_read_ready // Room for read words
);
    import mbq_pkg::*;

    typedef struct packed {
        logic [3:0][W-1:0] word;
        buf_flags_t pend;
        buf_flags_t ctb;
        buf_idx_t sel;
        logic [W-1:0] out;
        logic [`MBQ_DV_WAIT-1:0] dv;
        logic [`MBQ_DV_WAIT-1:0][1:0] dva;
        src_code_t code;
        buf_flags_t strobe;
        buf_idx_t cptr;
        logic busy;
        logic rd_act;
        logic first;
        logic one;
    } st_t;

    st_t s_r;
    st_t s_nxt;

    // Scan from cur upward, modulo 4, for the first set flag
    function automatic buf_idx_t next_pending(buf_flags_t f, buf_idx_t cur);
        buf_idx_t r;
        buf_idx_t c;
        r = cur;
        for (int i = 3; i >= 0; i--) begin
            c = cur + 2'(i);
            if (f[c]) begin
                r = c;
            end
        end
        return r;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Read data staging

    logic push_w;
    logic fifo_valid;
    logic fifo_pop;
    logic [W+1:0] fifo_word;
    buf_flags_t xfer_flags;

    assign push_w = s_r.dv[`MBQ_DV_WAIT-1];
    assign xfer_flags = cache_xfer_written_only ? cache_word_modified
                                                : cache_word_valid;

    word_fifo #(
        .W(W + 2),
        .DEPTH(FIFO_DEPTH)
    ) read_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push_w),
        .in_ready(bus_read_ready),
        .in_data({s_r.dva[`MBQ_DV_WAIT-1], mem_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_word)
    );

    //////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        buf_flags_t set;
        buf_flags_t clr;
        logic ld;
        buf_idx_t idx;
        logic [W-1:0] din;
        src_code_t code;
        set = '0;
        clr = '0;
        ld = 1'b0;
        idx = `MBQ_IDX_ZERO;
        din = cache_data;
        code = `MBQ_SRC_CACHE;
        fifo_pop = 1'b0;
        s_nxt = s_r;
        s_nxt.strobe = '0;
        s_nxt.dv = {s_r.dv[`MBQ_DV_WAIT-2:0], bus_read_word_valid};
        s_nxt.dva = {s_r.dva[`MBQ_DV_WAIT-2:0], core_addr_bits};
        // Fixed priority: cache, register, channel, then staged core words
        if (s_r.ctb != `MBQ_FLAGS_NONE && cache_transfer_phase_three) begin
            idx = s_r.cptr;
            ld = 1'b1;
            s_nxt.ctb[s_r.cptr] = 1'b0;
        end else if (single_word_write_phase || system_bus_diagnostic) begin
            code = `MBQ_SRC_AR;
            idx = physical_word_address_bits;
            din = arithmetic_register;
            ld = 1'b1;
        end else if (channel_buffer_load) begin
            code = channel_load_command ? `MBQ_SRC_CCW : `MBQ_SRC_CHBUF;
            idx = channel_buffer_select;
            din = channel_load_command ? command_word_mixer
                                       : channel_data_buffer;
            ld = 1'b1;
        end else if (fifo_valid && !s_r.pend[fifo_word[W+1:W]]) begin
            // Core words never overwrite a still pending buffer; they wait
            code = `MBQ_SRC_MEM;
            idx = fifo_word[W+1:W];
            din = fifo_word[W-1:0];
            ld = 1'b1;
            fifo_pop = 1'b1;
        end
        if (ld) begin
            s_nxt.word[idx] = din;
            set[idx] = 1'b1;
            s_nxt.strobe[idx] = 1'b1;
            s_nxt.code = code;
        end
        if (cache_xfer_load) begin
            s_nxt.ctb = s_nxt.ctb | xfer_flags;
            set = set | xfer_flags;
        end
        if (ar_word_taken || cache_word_written || page_table_written
                || bus_word_accepted) begin
            clr[s_r.sel] = 1'b1;
        end
        if (channel_read_take) begin
            clr[channel_buffer_select] = 1'b1;
        end
        // Loads win over clears in the same cycle
        s_nxt.pend = (s_r.pend & ~clr) | set;
        // Core read routing
        if (ar_word_taken) begin
            s_nxt.first = 1'b0;
        end
        // Bus gaps are unknown here: a read stays open until another
        // source loads a buffer or the next read starts
        if (ld && code != `MBQ_SRC_MEM) begin
            s_nxt.rd_act = 1'b0;
        end
        if (core_read_start) begin
            s_nxt.rd_act = 1'b1;
            s_nxt.first = 1'b1;
            s_nxt.one = core_read_one_word;
        end
        if (channel_read_active) begin
            s_nxt.sel = channel_buffer_select;
        end else begin
            s_nxt.sel = next_pending(s_nxt.pend, s_r.sel);
        end
        s_nxt.out = s_nxt.word[s_nxt.sel];
        s_nxt.cptr = next_pending(s_nxt.ctb, `MBQ_IDX_ZERO);
        s_nxt.busy = (s_nxt.pend != `MBQ_FLAGS_NONE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs

    assign buffer_out_data = s_r.out;
    assign buffer_output_select = s_r.sel;
    assign buffer_source_select_code = s_r.code;
    assign buffer_load_strobe = s_r.strobe;
    assign buffer_pending_flags = s_r.pend;
    assign cache_to_buffer_word_requests = s_r.ctb;
    assign cache_word_pointer = s_r.cptr;
    assign any_buffer_pending = s_r.busy;
    assign core_busy = s_r.busy;

    logic ar_rdy_r;
    logic csh_rq_r;
    // Register delivery hints; later words skip the register entirely
    always_ff @(posedge clk) begin
        if (rst) begin
            ar_rdy_r <= 1'b0;
            csh_rq_r <= 1'b0;
        end else begin
            ar_rdy_r <= s_nxt.rd_act && s_nxt.first
                        && s_nxt.pend[s_nxt.sel];
            csh_rq_r <= s_nxt.rd_act && !s_nxt.first && !s_nxt.one
                        && s_nxt.pend[s_nxt.sel];
        end
    end
    assign ar_word_ready = ar_rdy_r;
    assign cache_word_request = csh_rq_r;

    //////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_LOAD_SETS_FLAG: assert property (
        s_r.strobe != '0 |-> (s_r.strobe & ~s_r.pend) == '0)
        else $error("loaded buffer not pending");

    AST_ACK_CLEARS: assert property (
        (bus_word_accepted && !ld_any() && !cache_xfer_load
            && !channel_read_active) |=> !s_r.pend[$past(s_r.sel)])
        else $error("acknowledged buffer still pending");

    AST_BUSY_TRACKS: assert property (
        $fell(core_busy) |-> $past(s_r.pend != '0) && s_r.pend == '0)
        else $error("core freed with flags pending");

    AST_RESET_CLEAR: assert property (
        @(posedge clk) disable iff (1'b0)
        rst |=> s_r.pend == '0 && !core_busy)
        else $error("flags survive reset");

    AST_DV_WAIT: assert property (
        bus_read_word_valid |-> ##2 push_w)
        else $error("read word not staged after two ticks");

    AST_AR_SOURCE: assert property (
        (s_r.strobe != '0 && s_r.code == `MBQ_SRC_AR) |->
        $past(single_word_write_phase || system_bus_diagnostic)
        && s_r.strobe[$past(physical_word_address_bits)])
        else $error("register load wrong source or buffer");

    AST_NEXT_SELECT: assert property (
        (!$past(channel_read_active) && s_r.pend != '0) |->
        s_r.pend[s_r.sel])
        else $error("selected buffer not pending");

    AST_QUEUE_PAIR: assert property (
        (cache_xfer_load && !cache_transfer_phase_three) |=>
        (s_r.ctb & $past(xfer_flags)) == $past(xfer_flags)
        && (s_r.pend & $past(xfer_flags)) == $past(xfer_flags))
        else $error("word queue and flags not loaded together");

    AST_CHAN_SELECT: assert property (
        $past(channel_read_active) |->
        s_r.sel == $past(channel_buffer_select))
        else $error("channel read select ignored");

    COV_CACHE_LOAD: cover property (
        s_r.strobe != '0 && s_r.code == `MBQ_SRC_CACHE);
    COV_MEM_LOAD: cover property (
        s_r.strobe != '0 && s_r.code == `MBQ_SRC_MEM);
    COV_FIFO_FULL: cover property (!bus_read_ready);
    COV_ALL_PENDING: cover property (s_r.pend == 4'hF);

    function automatic logic ld_any();
        return single_word_write_phase || system_bus_diagnostic
               || channel_buffer_load || channel_read_take
               || (cache_transfer_phase_three && s_r.ctb != '0)
               || fifo_valid;
    endfunction
endmodule

/* verification/core_bus_model.sv */
`timescale 1ns/100ps
module core_bus_model #(
    parameter int W = 36
) (
    input wire logic clk, // Controller clock
    input wire logic start, // Begin a read burst
    input wire mbq_pkg::buf_idx_t first_word, // Word sent first
    input wire logic [3:0] words, // Words in the burst
    input wire logic [3:0] gap, // Idle ticks between words beyond the fixed three
    input wire logic [W-1:0] base, // Data of the first word
    output logic bus_read_word_valid, // Data valid pulse
    output mbq_pkg::buf_idx_t core_addr_bits, // Word on the bus
    output logic [W-1:0] mem_data // Read data
);
    import mbq_pkg::*;
    ////////////////////////////////////////
    initial begin
        bus_read_word_valid = 1'b0;
        core_addr_bits = 2'h0;
        mem_data = '0;
        forever begin
            @(posedge clk);
            if (start) begin
                for (int i = 0; i < int'(words); i++) begin
                    repeat (gap) @(negedge clk);
                    @(negedge clk);
                    // Words come ascending mod 4 from the first one
                    core_addr_bits = 2'(first_word + i);
                    mem_data = base + W'(i);
                    bus_read_word_valid = 1'b1;
                    @(negedge clk);
                    bus_read_word_valid = 1'b0;
                    repeat (2) @(negedge clk);
                    // Undriven lines: never leave a stale copy
                    core_addr_bits = ~core_addr_bits;
                    mem_data = ~mem_data;
                end
            end
        end
    end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/100ps
`include "mbq_defs.svh"
module tb_top;
    import mbq_pkg::*;
    localparam int W = 36;
    logic clk = '0, rst = '1, bus_read_word_valid, any_buffer_pending;
    logic single_word_write_phase = '0, system_bus_diagnostic = '0;
    logic cache_xfer_load = '0, cache_xfer_written_only = '0;
    logic cache_transfer_phase_three = '0, channel_buffer_load = '0;
    logic channel_load_command = '0, channel_read_active = '0;
    logic channel_read_take = '0, core_read_start = '0, m_start = '0;
    logic core_read_one_word = '0, ar_word_taken = '0, bus_word_accepted = '0;
    logic cache_word_written = '0, page_table_written = '0, core_busy;
    logic ar_word_ready, cache_word_request, bus_read_ready;
    logic [W-1:0] arithmetic_register = '0, cache_data = '0, mem_data;
    logic [W-1:0] channel_data_buffer = '0, command_word_mixer = '0;
    logic [W-1:0] m_base = '0, buffer_out_data, wd[4];
    buf_idx_t physical_word_address_bits = '0, channel_buffer_select = '0;
    buf_idx_t m_first = '0, core_addr_bits, buffer_output_select;
    buf_idx_t cache_word_pointer;
    buf_flags_t cache_word_modified = '0, cache_word_valid = '0;
    buf_flags_t buffer_load_strobe, buffer_pending_flags;
    buf_flags_t cache_to_buffer_word_requests;
    src_code_t buffer_source_select_code;
    logic [3:0] m_words = '0, m_gap = '0;
    logic [6:0] exp_q[$];
    int fails = 0, total_checks = 0, cycles = 0;

    always #4 clk = ~clk;

    memory_buffer_queue_control #(.W(W), .FIFO_DEPTH(`MBQ_FIFO_DEPTH))
    memory_buffer_queue_control_inst (.clk, .rst, .arithmetic_register,
        .cache_data, .mem_data, .channel_data_buffer, .command_word_mixer,
        .single_word_write_phase, .system_bus_diagnostic,
        .physical_word_address_bits, .cache_xfer_load,
        .cache_xfer_written_only, .cache_word_modified, .cache_word_valid,
        .cache_transfer_phase_three, .bus_read_word_valid, .core_addr_bits,
        .channel_buffer_load, .channel_load_command, .channel_buffer_select,
        .channel_read_active, .channel_read_take, .core_read_start,
        .core_read_one_word, .ar_word_taken, .cache_word_written,
        .page_table_written, .bus_word_accepted, .buffer_out_data,
        .buffer_output_select, .buffer_source_select_code,
        .buffer_load_strobe, .buffer_pending_flags,
        .cache_to_buffer_word_requests, .cache_word_pointer,
        .any_buffer_pending, .core_busy, .ar_word_ready,
        .cache_word_request, .bus_read_ready);

    core_bus_model #(.W(W)) core_bus_model_inst (.clk, .start(m_start),
        .first_word(m_first), .words(m_words), .gap(m_gap), .base(m_base),
        .bus_read_word_valid, .core_addr_bits, .mem_data);

    ////////////////////////////////////////
    task automatic check_val(input logic [W-1:0] e, input logic [W-1:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic check_load(input logic [6:0] e, input logic [6:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic finish_test();
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Kind: 0 register, 1 cache, 2 page table, 3 bus acknowledge
    task automatic clear_one(input int k);
        {bus_word_accepted, page_table_written, cache_word_written,
            ar_word_taken} = 4'h1 << k;
        @(negedge clk);
        {bus_word_accepted, page_table_written, cache_word_written,
            ar_word_taken} = 4'h0;
        // Quiet edge keeps back-to-back clear pulses distinct
        @(negedge clk);
    endtask

    function automatic buf_idx_t next_sel(buf_flags_t f, buf_idx_t c);
        for (int i = 1; i <= 4; i++) begin
            if (f[2'(c + i)]) return 2'(c + i);
        end
        return c;
    endfunction

    // Every strobe must match the oldest expected load
    always @(negedge clk) begin
        if (!rst && buffer_load_strobe !== 4'h0) begin
            check_load(exp_q.size() > 0 ? exp_q.pop_front() : 7'h7f,
                {buffer_load_strobe, buffer_source_select_code});
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end

    ////////////////////////////////////////
    initial begin
        int n;
        buf_flags_t f;
        buf_idx_t s;
        void'($urandom(81));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        check_val(4'h0, buffer_pending_flags);
        check_val(3'h1,
            {core_busy, any_buffer_pending, bus_read_ready});
        for (int d = 0; d < 2; d++) begin
            arithmetic_register = W'({$urandom(), $urandom()});
            wd[2 - d] = arithmetic_register;
            physical_word_address_bits = 2'(2 - d);
            {system_bus_diagnostic, single_word_write_phase} = 2'h1 << d;
            exp_q.push_back({4'h4 >> d, `MBQ_SRC_AR});
            @(negedge clk);
            check_val(4'h4 | (4'h2 * d), buffer_pending_flags);
            check_val(1'b1, core_busy);
            check_val(wd[2], buffer_out_data);
        end
        {system_bus_diagnostic, single_word_write_phase} = 2'h0;
        for (int c = 0; c < 2; c++) begin
            channel_data_buffer = W'({$urandom(), $urandom()});
            command_word_mixer = ~channel_data_buffer;
            wd[c ? 0 : 3] = c ? command_word_mixer : channel_data_buffer;
            channel_load_command = c[0];
            channel_buffer_select = c ? 2'h0 : 2'h3;
            channel_buffer_load = 1'b1;
            exp_q.push_back({c ? 4'h1 : 4'h8,
                c ? `MBQ_SRC_CCW : `MBQ_SRC_CHBUF});
            @(negedge clk);
        end
        channel_buffer_load = 1'b0;
        s = 2'h2;
        f = 4'hf;
        for (int k = 0; k < 4; k++) begin
            check_val(wd[s], buffer_out_data);
            clear_one((k + 1) % 4);
            f[s] = 1'b0;
            s = next_sel(f, s);
            check_val(f, buffer_pending_flags);
            check_val(s, buffer_output_select);
        end
        check_val(1'b0, core_busy);
        for (int wo = 1; wo >= 0; wo--) begin
            cache_word_modified = 4'($urandom()) | 4'h1;
            cache_word_valid = ~cache_word_modified | 4'h8;
            f = wo ? cache_word_modified : cache_word_valid;
            cache_xfer_written_only = wo[0];
            cache_xfer_load = 1'b1;
            @(negedge clk);
            cache_xfer_load = 1'b0;
            check_val(f, buffer_pending_flags);
            check_val(f, cache_to_buffer_word_requests);
            for (int i = 0; i < 4; i++) begin
                if (f[i]) begin
                    check_val(i, cache_word_pointer);
                    cache_data = W'({$urandom(), $urandom()});
                    wd[i] = cache_data;
                    cache_transfer_phase_three = 1'b1;
                    exp_q.push_back({4'h1 << i, `MBQ_SRC_CACHE});
                    @(negedge clk);
                    cache_transfer_phase_three = 1'b0;
                    @(negedge clk);
                end
            end
            check_val(4'h0, cache_to_buffer_word_requests);
            channel_read_active = 1'b1;
            for (int i = 0; i < 4; i++) begin
                if (f[i]) begin
                    channel_buffer_select = 2'(i);
                    @(negedge clk);
                    check_val(wd[i], buffer_out_data);
                    channel_read_take = 1'b1;
                    @(negedge clk);
                    channel_read_take = 1'b0;
                    f[i] = 1'b0;
                    check_val(f, buffer_pending_flags);
                end
            end
            channel_read_active = 1'b0;
        end
        // Third burst outruns the buffers and fills the staging FIFO
        for (int p = 0; p < 3; p++) begin
            core_read_one_word = (p == 0);
            m_words = p == 0 ? 4'h1 : (p == 1 ? 4'h4 : 4'hc);
            m_first = 2'($urandom());
            m_gap = 4'($urandom() % 4);
            m_base = W'({$urandom(), $urandom()});
            for (int i = 0; i < int'(m_words); i++) begin
                exp_q.push_back({4'h1 << 2'(m_first + i),
                    `MBQ_SRC_MEM});
            end
            {core_read_start, m_start} = 2'h3;
            @(negedge clk);
            {core_read_start, m_start} = 2'h0;
            for (n = 0; n < 100 && ar_word_ready !== 1'b1; n++) begin
                @(negedge clk);
            end
            check_val(1'b1, ar_word_ready);
            check_val(m_base, buffer_out_data);
            if (p == 2) begin
                for (n = 0; n < 200 && bus_read_ready !== 1'b0; n++) begin
                    @(negedge clk);
                end
                check_val(1'b0, bus_read_ready);
            end
            clear_one(0);
            for (int k = 1; k < int'(m_words); k++) begin
                s = 2'(m_first + k);
                for (n = 0; n < 100 && !(buffer_output_select === s &&
                    buffer_pending_flags[s] === 1'b1); n++) @(negedge clk);
                check_val(1'b1, cache_word_request);
                check_val(m_base + W'(k), buffer_out_data);
                clear_one(1);
            end
            check_val(3'h1,
                {cache_word_request, core_busy, bus_read_ready});
        end
        check_val(0, exp_q.size());
        finish_test();
    end
endmodule
